// ==== inc/rtc_value_pkg.sv ====
// Purpose: shared constants for the calendar date and alarm value registers
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   offsets are byte addresses

package rtc_value_pkg;

	// ----------------------------------------
	// bus shape
	// ----------------------------------------
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned STRB_W = DATA_W / 8;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] DATE_OFF  = 8'h00;
	localparam logic [7:0] ATIME_OFF = 8'h04;
	localparam logic [7:0] ADATE_OFF = 8'h08;
	localparam logic [7:0] CTRL_OFF  = 8'h0c;
	localparam logic [7:0] ISTAT_OFF = 8'h10;
	localparam logic [7:0] IMASK_OFF = 8'h14;

	// ----------------------------------------
	// digit positions (lsb of each field)
	// ----------------------------------------
	localparam int unsigned YEAR_T_LSB  = 28;
	localparam int unsigned YEAR_U_LSB  = 24;
	localparam int unsigned MONTH_T_BIT = 20;
	localparam int unsigned MONTH_U_LSB = 16;
	localparam int unsigned DAY_T_LSB   = 12;
	localparam int unsigned DAY_U_LSB   = 8;
	localparam int unsigned WDAY_LSB    = 0;
	localparam int unsigned HOUR_T_LSB  = 28;
	localparam int unsigned HOUR_U_LSB  = 24;
	localparam int unsigned MIN_T_LSB   = 20;
	localparam int unsigned MIN_U_LSB   = 16;
	localparam int unsigned SEC_T_LSB   = 12;
	localparam int unsigned SEC_U_LSB   = 8;

	// implemented bits of each value word
	localparam logic [31:0] DATE_IMPL  = 32'hff1f_3f07;
	localparam logic [31:0] ATIME_IMPL = 32'h3f7f_7f00;
	localparam logic [31:0] ADATE_IMPL = 32'h001f_3f07;

	// ----------------------------------------
	// control word
	// ----------------------------------------
	localparam int unsigned WREN_BIT  = 0;
	localparam int unsigned ALARM_MATCH_MASK_LSB = 8;
	localparam int unsigned ALARM_MATCH_MASK_W   = 4;
	localparam logic [3:0]  ALARM_MATCH_MASK_MAX = 4'h9;
	localparam logic        WREN_RST  = 1'b0;
	localparam logic [3:0]  ALARM_MATCH_MASK_RST = 4'h0;

	// ----------------------------------------
	// interrupt events
	// ----------------------------------------
	localparam int unsigned EV_W       = 2;
	localparam int unsigned EV_BLOCKED = 0;
	localparam int unsigned EV_RESVD   = 1;
	localparam logic [1:0]  EV_RST     = 2'h0;

	// ----------------------------------------
	// bus answer sequencing
	// ----------------------------------------
	typedef enum logic [1:0] {
		st_idle   = 2'b01,
		st_answer = 2'b10
	} bus_state_t;

endpackage : rtc_value_pkg

// ==== design/value_word.sv ====
// Purpose: one value word of packed decimal digits
// Assumes: caller supplies the merged write image
// Notes:   no reset, contents unknown until loaded

`timescale 1ns/1ps

module value_word #(
	parameter logic [31:0] IMPL = 32'hffff_ffff
) (
	input  wire logic        pclk,
	input  wire logic        ce,
	input  wire logic        we,
	input  wire logic [31:0] wdata,
	output logic      [31:0] q
);

	logic [31:0] word_q;

	// left unreset on purpose: software loads it before use
	always_ff @(posedge pclk) begin
		if (ce && we) begin
			word_q <= wdata & IMPL; // stored as given, no range
		end
	end

	// unimplemented bits never hold anything, so they read zero
	assign q = word_q & IMPL;

endmodule : value_word

// ==== design/rtc_value_regs.sv ====
// Purpose: calendar date and alarm value registers behind an APB slave
// Assumes: single clock pclk, pce freezes all state while low
// Notes:   control, interrupt status and mask words live beside them
//
// Functional notes
// - year as two decimal digits, bits 31-24
// - month tens bit 20, units 19-16
// - day tens 13-12, units 11-8
// - weekday field bits 2-0, values 0-6
// - date unimplemented bits read zero
// - date writes only while write enable set
// - alarm hour tens 29-28, units 27-24
// - alarm minute tens 22-20, units 19-16
// - alarm second tens 14-12, units 11-8
// - alarm time unimplemented bits read zero
// - alarm month tens bit 20, units 19-16
// - alarm day tens 13-12, units 11-8
// - alarm weekday bits 2-0, values 0-6
// - alarm date unimplemented bits read zero
// - value fields unknown after reset
// - four-bit alarm mask, codes above 1001 reserved
//
// The address map and the APB slave port are this design's own decisions.

`timescale 1ns/1ps

module rtc_value_regs #(
	parameter int unsigned ADDR_W = rtc_value_pkg::ADDR_W
) (
	input  wire logic                                pclk,
	input  wire logic                                presetn,
	input  wire logic                                pce,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [ADDR_W-1:0]                   paddr,
	input  wire logic [rtc_value_pkg::STRB_W-1:0]    pstrb,
	input  wire logic [rtc_value_pkg::DATA_W-1:0]    pwdata,
	output logic      [rtc_value_pkg::DATA_W-1:0]    prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	output logic                                     irq,
	output logic                                     clock_write_enable,
	output logic      [rtc_value_pkg::ALARM_MATCH_MASK_W-1:0]   alarm_match_mask
);

	import rtc_value_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------

	function automatic logic hit(
		input logic [ADDR_W-1:0] addr,
		input logic [7:0]        off
	);
		logic [ADDR_W-1:0] wide;
		wide = ADDR_W'(off);
		return addr[ADDR_W-1:2] == wide[ADDR_W-1:2];
	endfunction : hit

	// byte lanes without a strobe keep their old contents
	function automatic logic [DATA_W-1:0] merge(
		input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] nxt,
		input logic [STRB_W-1:0] strb
	);
		logic [DATA_W-1:0] res;
		res = old;
		for (int i = 0; i < STRB_W; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nxt[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	// ----------------------------------------
	// state
	// ----------------------------------------

	bus_state_t          state_q;
	bus_state_t          state_d;
	logic [DATA_W-1:0]   prdata_q;
	logic [DATA_W-1:0]   prdata_d;
	logic                pready_q;
	logic                pslverr_q;
	logic                irq_q;
	logic                wren_q;
	logic                wren_d;
	logic [ALARM_MATCH_MASK_W-1:0]  alarm_match_mask_q;
	logic [ALARM_MATCH_MASK_W-1:0]  alarm_match_mask_d;
	logic [EV_W-1:0]     status_q;
	logic [EV_W-1:0]     status_d;
	logic [EV_W-1:0]     mask_q;
	logic [EV_W-1:0]     mask_d;

	logic [DATA_W-1:0]   date_q;
	logic [DATA_W-1:0]   atime_q;
	logic [DATA_W-1:0]   adate_q;

	// ----------------------------------------
	// address decode and bus phases
	// ----------------------------------------

	wire sel_date  = hit(paddr, DATE_OFF);
	wire sel_atime = hit(paddr, ATIME_OFF);
	wire sel_adate = hit(paddr, ADATE_OFF);
	wire sel_ctrl  = hit(paddr, CTRL_OFF);
	wire sel_istat = hit(paddr, ISTAT_OFF);
	wire sel_imask = hit(paddr, IMASK_OFF);

	wire mapped = sel_date | sel_atime | sel_adate
		| sel_ctrl | sel_istat | sel_imask;

	wire access = psel & penable;

	// first access cycle: prepare the answer
	wire take = access & (state_q == st_idle);

	// edge at which the master sees pready: write takes effect here
	wire commit = access & (state_q == st_answer);
	wire wr     = commit & pwrite & mapped;

	// ----------------------------------------
	// date digits
	// ----------------------------------------

	wire [3:0] year_tens_digit   = date_q[YEAR_T_LSB +: 4];
	wire [3:0] year_units_digit  = date_q[YEAR_U_LSB +: 4];
	wire       month_tens_digit  = date_q[MONTH_T_BIT];
	wire [3:0] month_units_digit = date_q[MONTH_U_LSB +: 4];
	wire [1:0] day_tens_digit    = date_q[DAY_T_LSB +: 2];
	wire [3:0] day_units_digit   = date_q[DAY_U_LSB +: 4];
	wire [2:0] weekday_digit     = date_q[WDAY_LSB +: 3];

	// gaps are constant zero, never storage
	wire [DATA_W-1:0] date_rd = {
		year_tens_digit,
		year_units_digit,
		3'h0,
		month_tens_digit,
		month_units_digit,
		2'h0,
		day_tens_digit,
		day_units_digit,
		5'h00,
		weekday_digit
	};

	// ----------------------------------------
	// alarm time digits
	// ----------------------------------------

	wire [1:0] hour_tens_digit    = atime_q[HOUR_T_LSB +: 2];
	wire [3:0] hour_units_digit   = atime_q[HOUR_U_LSB +: 4];
	wire [2:0] minute_tens_digit  = atime_q[MIN_T_LSB +: 3];
	wire [3:0] minute_units_digit = atime_q[MIN_U_LSB +: 4];
	wire [2:0] second_tens_digit  = atime_q[SEC_T_LSB +: 3];
	wire [3:0] second_units_digit = atime_q[SEC_U_LSB +: 4];

	wire [DATA_W-1:0] atime_rd = {
		2'h0,
		hour_tens_digit,
		hour_units_digit,
		1'b0,
		minute_tens_digit,
		minute_units_digit,
		1'b0,
		second_tens_digit,
		second_units_digit,
		8'h00
	};

	// ----------------------------------------
	// alarm date digits
	// ----------------------------------------

	wire       al_month_tens  = adate_q[MONTH_T_BIT];
	wire [3:0] al_month_units = adate_q[MONTH_U_LSB +: 4];
	wire [1:0] al_day_tens    = adate_q[DAY_T_LSB +: 2];
	wire [3:0] al_day_units   = adate_q[DAY_U_LSB +: 4];
	wire [2:0] al_weekday     = adate_q[WDAY_LSB +: 3];

	wire [DATA_W-1:0] adate_rd = {
		11'h000,
		al_month_tens,
		al_month_units,
		2'h0,
		al_day_tens,
		al_day_units,
		5'h00,
		al_weekday
	};

	// ----------------------------------------
	// control and interrupt words
	// ----------------------------------------

	wire [DATA_W-1:0] ctrl_rd = DATA_W'({alarm_match_mask_q, 7'h00, wren_q});
	wire [DATA_W-1:0] istat_rd = DATA_W'(status_q);
	wire [DATA_W-1:0] imask_rd = DATA_W'(mask_q);

	wire [DATA_W-1:0] rd_word =
		sel_date  ? date_rd  :
		sel_atime ? atime_rd :
		sel_adate ? adate_rd :
		sel_ctrl  ? ctrl_rd  :
		sel_istat ? istat_rd :
		sel_imask ? imask_rd : '0;

	// ----------------------------------------
	// value word writes
	// ----------------------------------------

	// date is locked unless the write enable is set
	wire we_date  = wr & sel_date & wren_q;
	wire we_atime = wr & sel_atime;
	wire we_adate = wr & sel_adate;

	wire [DATA_W-1:0] date_wd  = merge(date_q, pwdata, pstrb);
	wire [DATA_W-1:0] atime_wd = merge(atime_q, pwdata, pstrb);
	wire [DATA_W-1:0] adate_wd = merge(adate_q, pwdata, pstrb);

	value_word #(.IMPL(DATE_IMPL)) u_date (
		.pclk  (pclk),
		.ce    (pce),
		.we    (we_date),
		.wdata (date_wd),
		.q     (date_q)
	);

	value_word #(.IMPL(ATIME_IMPL)) u_atime (
		.pclk  (pclk),
		.ce    (pce),
		.we    (we_atime),
		.wdata (atime_wd),
		.q     (atime_q)
	);

	value_word #(.IMPL(ADATE_IMPL)) u_adate (
		.pclk  (pclk),
		.ce    (pce),
		.we    (we_adate),
		.wdata (adate_wd),
		.q     (adate_q)
	);

	// ----------------------------------------
	// control word update
	// ----------------------------------------

	wire [DATA_W-1:0]  ctrl_wd   = merge(ctrl_rd, pwdata, pstrb);
	wire               we_ctrl   = wr & sel_ctrl;
	wire [ALARM_MATCH_MASK_W-1:0] alarm_match_mask_new = ctrl_wd[ALARM_MATCH_MASK_LSB +: ALARM_MATCH_MASK_W];

	// a reserved mask code is refused so the match never sees it
	wire alarm_match_mask_bad = alarm_match_mask_new > ALARM_MATCH_MASK_MAX;

	assign wren_d = we_ctrl ? ctrl_wd[WREN_BIT] : wren_q;
	assign alarm_match_mask_d = (we_ctrl && !alarm_match_mask_bad) ? alarm_match_mask_new : alarm_match_mask_q;

	// ----------------------------------------
	// interrupt events
	// ----------------------------------------

	wire ev_blocked = wr & sel_date & ~wren_q;
	wire ev_resvd   = we_ctrl & alarm_match_mask_bad;

	wire [EV_W-1:0] ev_set = {ev_resvd, ev_blocked};

	// both event bits sit in byte lane 0, so only that strobe matters
	wire              we_istat = wr & sel_istat & pstrb[0];
	wire [EV_W-1:0]   w1c      = we_istat ? pwdata[EV_W-1:0] : '0;
	wire [DATA_W-1:0] imask_wd = merge(imask_rd, pwdata, pstrb);

	// set beats clear in the same cycle
	assign status_d = (status_q & ~w1c) | ev_set;
	assign mask_d = (wr & sel_imask) ? imask_wd[EV_W-1:0] : mask_q;

	// ----------------------------------------
	// bus answer
	// ----------------------------------------

	// a stray code would stall the bus for good, so fall back to idle
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			st_idle: begin
				if (take) begin
					state_d = st_answer;
				end
			end
			st_answer: begin
				if (commit) begin
					state_d = st_idle;
				end
			end
			default: begin
				state_d = st_idle;
			end
		endcase
	end

	assign prdata_d = (take && !pwrite) ? rd_word : '0;

	// ----------------------------------------
	// flops
	// ----------------------------------------

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q   <= st_idle;
			prdata_q  <= '0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else if (pce) begin
			state_q   <= state_d;
			prdata_q  <= prdata_d;
			pready_q  <= take;
			pslverr_q <= take & ~mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wren_q   <= WREN_RST;
			alarm_match_mask_q  <= ALARM_MATCH_MASK_RST;
			status_q <= EV_RST;
			mask_q   <= EV_RST;
			irq_q    <= 1'b0;
		end else if (pce) begin
			wren_q   <= wren_d;
			alarm_match_mask_q  <= alarm_match_mask_d;
			status_q <= status_d;
			mask_q   <= mask_d;
			irq_q    <= |(status_d & mask_d);
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------

	assign prdata             = prdata_q;
	assign pready             = pready_q;
	assign pslverr            = pslverr_q;
	assign irq                = irq_q;
	assign clock_write_enable = wren_q;
	assign alarm_match_mask   = alarm_match_mask_q;

endmodule : rtc_value_regs

// ==== verif/rtc_value_regs_assertions.sv ====
// Purpose: port checks on the date and alarm value register block
// Assumes: an access seen while pce is high is answered one wait state late
// Notes:   bound into rtc_value_regs below
`timescale 1ns/1ps

module rtc_value_regs_assertions
	import rtc_value_pkg::*;
#(
	parameter int unsigned ADDR_W = 8
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              pce,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [3:0]        pstrb,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [3:0]        alarm_match_mask,
	input wire logic              clock_write_enable
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------
	// transfer steps
	// ----------------------------------------
	sequence s_done;
		psel && penable && pready;
	endsequence
	sequence s_rd_at(logic [5:0] w);
		s_done ##0 (!pwrite && paddr[7:2] == w);
	endsequence
	sequence s_ctrl_wr;
		s_done ##0 (pwrite && paddr[7:2] == CTRL_OFF[7:2] && pstrb[1]);
	endsequence

	property p_one_wait;
		pce && psel && penable && !pready |=> pready;
	endproperty
	property p_pulse;
		pready |=> !pready;
	endproperty
	property p_idle_zero;
		!pready |-> prdata == 32'h0;
	endproperty
	property p_date_gap;
		s_rd_at(DATE_OFF[7:2]) |-> (prdata & ~DATE_IMPL) == 32'h0;
	endproperty
	property p_atime_gap;
		s_rd_at(ATIME_OFF[7:2]) |-> (prdata & ~ATIME_IMPL) == 32'h0;
	endproperty
	property p_adate_gap;
		s_rd_at(ADATE_OFF[7:2]) |-> (prdata & ~ADATE_IMPL) == 32'h0;
	endproperty
	property p_unmapped;
		s_done ##0 (paddr[7:2] > 6'h05) |-> pslverr && prdata == 32'h0;
	endproperty
	property p_mask_keep;
		s_ctrl_wr ##0 (pwdata[11:8] > ALARM_MATCH_MASK_MAX) |=> $stable(alarm_match_mask);
	endproperty
	property p_mask_take;
		s_ctrl_wr ##0 (pwdata[11:8] <= ALARM_MATCH_MASK_MAX) |=> alarm_match_mask == $past(pwdata[11:8]);
	endproperty
	property p_wren;
		s_done ##0 (pwrite && paddr[7:2] == CTRL_OFF[7:2] && pstrb[0]) |=> clock_write_enable == $past(pwdata[0]);
	endproperty

	a_one_wait: assert property (p_one_wait) else $error("no answer after one wait state");
	a_pulse: assert property (p_pulse) else $error("ready held over two cycles");
	a_idle_zero: assert property (p_idle_zero) else $error("read data not zero while idle");
	a_date_gap: assert property (p_date_gap) else $error("date gap bits not zero");
	a_atime_gap: assert property (p_atime_gap) else $error("alarm time gap bits not zero");
	a_adate_gap: assert property (p_adate_gap) else $error("alarm date gap bits not zero");
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	a_mask_keep: assert property (p_mask_keep) else $error("reserved mask code taken");
	a_mask_take: assert property (p_mask_take) else $error("valid mask code not taken");
	a_wren: assert property (p_wren) else $error("write enable copy wrong");
endmodule : rtc_value_regs_assertions

bind rtc_value_regs rtc_value_regs_assertions #(.ADDR_W(ADDR_W)) rtc_value_regs_assertions_i (
	.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pstrb(pstrb), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .alarm_match_mask(alarm_match_mask), .clock_write_enable(clock_write_enable));

// ==== verif/rtc_value_regs_tb.sv ====
// Purpose: directed bench for the date and alarm value registers
// Assumes: pce high except in the freeze test; one idle cycle between transfers
// Notes:   value words are unknown until first loaded
`timescale 1ns/1ps

module rtc_value_regs_tb;
	import rtc_value_pkg::*;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        pce     = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [3:0]  pstrb   = 4'h0;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        clock_write_enable;
	logic [3:0]  alarm_match_mask;
	logic [31:0] rd;
	logic        er;
	logic [3:0]  em;
	int          n_fail = 0;
	int          checks = 0;

	always #5 pclk = ~pclk;

	rtc_value_regs rtc_value_regs_i (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.clock_write_enable(clock_write_enable), .alarm_match_mask(alarm_match_mask));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	// request held until the edge that samples pready high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		chk("wait states", 2, n);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// outputs launched at this edge are read once they have settled
		@(negedge pclk);
	endtask : bus

	task automatic wrrd(input string nm, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		bus(1'b1, a, d, 4'hf);
		bus(1'b0, a, 32'h0, 4'h0);
		chk(nm, e, rd);
	endtask : wrrd

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		bus(1'b0, DATE_OFF, 32'h0, 4'h0);
		chk("date gaps", 32'h0, rd & ~DATE_IMPL);
		chk("err mapped", 0, er);
		chk("wren", 0, clock_write_enable);
		chk("mask", 0, alarm_match_mask);
		chk("irq", 0, irq);
		$display("reset test done");
	endtask : t_reset

	task automatic t_date;
		bus(1'b1, CTRL_OFF, 32'h1, 4'hf);
		chk("wren", 1, clock_write_enable);
		wrrd("date ones", DATE_OFF, 32'hffff_ffff, DATE_IMPL);
		wrrd("date", DATE_OFF, 32'h2519_3105, 32'h2519_3105);
		bus(1'b1, DATE_OFF, 32'h0000_0006, 4'h1);
		bus(1'b0, DATE_OFF, 32'h0, 4'h0);
		chk("date lane", 32'h2519_3106, rd);
		bus(1'b1, 8'h00, 32'h0, 4'h1);
		bus(1'b1, IMASK_OFF, 32'h1, 4'hf);
		bus(1'b1, CTRL_OFF, 32'h0, 4'hf);
		wrrd("date locked", DATE_OFF, 32'h0, 32'h2519_3100);
		@(posedge pclk);
		chk("irq set", 1, irq);
		bus(1'b1, ISTAT_OFF, 32'h1, 4'hf);
		@(posedge pclk);
		chk("irq clear", 0, irq);
		bus(1'b1, IMASK_OFF, 32'h0, 4'hf);
		bus(1'b1, DATE_OFF, 32'h0, 4'hf);
		bus(1'b0, ISTAT_OFF, 32'h0, 4'h0);
		chk("status", 32'h1, rd);
		chk("irq masked", 0, irq);
		$display("date test done");
	endtask : t_date

	task automatic t_alarm;
		wrrd("atime ones", ATIME_OFF, 32'hffff_ffff, ATIME_IMPL);
		wrrd("atime", ATIME_OFF, 32'h2359_5900, 32'h2359_5900);
		wrrd("adate ones", ADATE_OFF, 32'hffff_ffff, ADATE_IMPL);
		wrrd("adate", ADATE_OFF, 32'h0012_3106, 32'h0012_3106);
		$display("alarm test done");
	endtask : t_alarm

	task automatic t_mask;
		em = 4'h0;
		for (int c = 0; c < 16; c++) begin
			bus(1'b1, CTRL_OFF, {20'h0, 4'(c), 8'h01}, 4'hf);
			if (c <= 9) em = 4'(c);
			chk("mask", em, alarm_match_mask);
		end
		bus(1'b0, ISTAT_OFF, 32'h0, 4'h0);
		chk("reserved flag", 32'h3, rd);
		$display("mask test done");
	endtask : t_mask

	// an access held while the enable is low must neither answer nor commit
	task automatic t_freeze;
		@(posedge pclk);
		pce <= 1'b0;
		psel <= 1'b1;
		pwrite <= 1'b1;
		paddr <= CTRL_OFF;
		pwdata <= 32'h0;
		pstrb <= 4'hf;
		@(posedge pclk);
		penable <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("frozen ready", 0, pready);
		chk("frozen wren", 1, clock_write_enable);
		pce <= 1'b1;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
		chk("frozen wren after", 1, clock_write_enable);
		$display("freeze test done");
	endtask : t_freeze

	task automatic t_unmapped;
		bus(1'b0, 8'h18, 32'h0, 4'h0);
		chk("err rd", 1, er);
		chk("rd zero", 32'h0, rd);
		bus(1'b1, 8'hfc, 32'h1, 4'hf);
		chk("err wr", 1, er);
		$display("unmapped test done");
	endtask : t_unmapped

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_date();
		t_alarm();
		t_mask();
		t_freeze();
		t_unmapped();
		complete_run();
	end

	// whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge pclk);
		n_fail++;
		complete_run();
	end
endmodule : rtc_value_regs_tb
